// ### core/encoder_fault_diagnostics.sv
// Purpose: diagnostic flags and power-up marking of the incremental outputs
// Assumes: angle front end supplies a position and a field status
// Notes:   resetn is the power-on reset; supply loss holds the pins low
//          externally, the logic drives the flags low while in reset

module encoder_fault_diagnostics
   import diag_pkg::*;
#(
   parameter int unsigned SAMPLE_CNT = SAMPLE_CYCLES,
   parameter int unsigned SETTLE_CNT = POWERUP_SETTLE_CYCLES
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // pins from outside
   input  wire logic             chip_select_n,
   input  wire field_stat_t      field_stat,
   input  wire logic [POS_W-1:0] position,
   // field flags, open drain
   output logic                  field_increase_flag_n_o,
   output logic                  field_increase_flag_n_oe,
   output logic                  field_decrease_flag_n_o,
   output logic                  field_decrease_flag_n_oe,
   // incremental outputs
   output incr_t                 incr_out,
   output logic                  startup_done
);
   typedef enum logic [1:0] {ST_WAIT_CS, ST_SETTLE, ST_RUN} mode_t;

   mode_t            mode_q;
   logic             cs_n_s;
   field_stat_t      fs_s;
   logic [31:0]      settle_q;
   logic [31:0]      tick_cnt_q;
   logic             tick_q;
   logic [POS_W-1:0] pos_q;
   logic             first_q;

   // every check below runs on the system clock, off during power-on reset
   default clocking cb_sys @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // chip select may be strapped at power-up; reset value high (inactive)
   sync2 #(.W(1), .RST_VAL(1'b1)) u_cs_sync (
      .clk    (clk),
      .resetn (resetn),
      .d      (chip_select_n),
      .q      (cs_n_s)
   );

   // status bits are slow levels; a one-cycle skew only delays a flag
   sync2 #(.W(4), .RST_VAL(4'h0)) u_fs_sync (
      .clk    (clk),
      .resetn (resetn),
      .d      (field_stat),
      .q      (fs_s)
   );

   // quadrature phase of a position: low two bits pick the A/B state
   function automatic incr_t quad_of(input logic [POS_W-1:0] p);
      incr_t r;
      r.a     = p[1];
      r.b     = p[1] ^ p[0];
      r.index = (p == '0);
      return r;
   endfunction

   // start-up sequence
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode_q   <= ST_SETTLE;
         settle_q <= 32'h0;
      end else begin
         case (mode_q)
            ST_SETTLE: begin
               // compensation runs once after reset regardless of select
               if (settle_q >= SETTLE_CNT - 1) begin
                  mode_q <= cs_n_s ? ST_WAIT_CS : ST_RUN;
               end else begin
                  settle_q <= settle_q + 32'h1;
               end
            end
            ST_WAIT_CS: begin
               if (!cs_n_s) begin
                  mode_q <= ST_RUN;
               end
            end
            ST_RUN: mode_q <= ST_RUN;
            default: mode_q <= ST_SETTLE;
         endcase
      end
   end

   // sample period tick; free-running, so the first refresh after run
   // entry may come up to one period late
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tick_cnt_q <= 32'h0;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q >= SAMPLE_CNT - 1) begin
         tick_cnt_q <= 32'h0;
         tick_q     <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h1;
         tick_q     <= 1'b0;
      end
   end

   // incremental outputs
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         incr_out <= INCR_ALL_HIGH;
         pos_q    <= '0;
         first_q  <= 1'b1;
      end else if (mode_q != ST_RUN) begin
         incr_out <= INCR_ALL_HIGH;
      end else if (first_q) begin
         // load current position, suppress index on this first update
         pos_q          <= position;
         first_q        <= 1'b0;
         incr_out       <= quad_of(position);
         incr_out.index <= 1'b0;
      end else if (tick_q) begin
         pos_q    <= position;
         incr_out <= quad_of(position);
      end
   end

   // field flags: oe high pulls the pin low
   // rising and falling together is ambiguous: release both, do not guess
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         field_increase_flag_n_oe <= 1'b1;
         field_decrease_flag_n_oe <= 1'b1;
      end else if (fs_s.too_strong || fs_s.too_weak) begin
         field_increase_flag_n_oe <= 1'b1;
         field_decrease_flag_n_oe <= 1'b1;
      end else begin
         field_increase_flag_n_oe <= fs_s.rising && !fs_s.falling;
         field_decrease_flag_n_oe <= fs_s.falling && !fs_s.rising;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         field_increase_flag_n_o <= 1'b0;
         field_decrease_flag_n_o <= 1'b0;
         startup_done            <= 1'b0;
      end else begin
         field_increase_flag_n_o <= 1'b0;
         field_decrease_flag_n_o <= 1'b0;
         startup_done            <= (mode_q == ST_RUN);
      end
   end

   // all three high only outside run mode and in the first run cycle
   incr_exclusive_a : assert property (
      (mode_q == ST_RUN && !first_q) |=> !(&incr_out))
      else $error("A, B and index all high in run mode");
   hold_high_a : assert property (
      (mode_q == ST_WAIT_CS) |=> (incr_out == INCR_ALL_HIGH))
      else $error("outputs not all high while waiting for select");
   settle_exit_a : assert property (
      (mode_q == ST_SETTLE && !cs_n_s && settle_q >= SETTLE_CNT - 1)
      |=> (mode_q == ST_RUN))
      else $error("settle did not end into run with select low");
   settle_high_a : assert property (
      (mode_q == ST_SETTLE) |=> (incr_out == INCR_ALL_HIGH))
      else $error("outputs not all high during compensation");
   run_sticky_a : assert property (
      (mode_q == ST_RUN) |=> (mode_q == ST_RUN && startup_done))
      else $error("run mode left or not reported");

   out_range_a : assert property (
      (fs_s.too_strong || fs_s.too_weak)
      |=> (field_increase_flag_n_oe && field_decrease_flag_n_oe))
      else $error("flags not both low on out-of-range field");
   approach_a : assert property (
      (!fs_s.too_strong && !fs_s.too_weak && fs_s.rising && !fs_s.falling)
      |=> (field_increase_flag_n_oe && !field_decrease_flag_n_oe))
      else $error("approach did not assert increase flag alone");
   recede_a : assert property (
      (!fs_s.too_strong && !fs_s.too_weak && !fs_s.rising && fs_s.falling)
      |=> (!field_increase_flag_n_oe && field_decrease_flag_n_oe))
      else $error("recede did not assert decrease flag alone");
   in_range_a : assert property (
      (fs_s == 4'h0)
      |=> (!field_increase_flag_n_oe && !field_decrease_flag_n_oe))
      else $error("flags driven with field in range");
   pin_low_a : assert property (
      ##1 (!field_increase_flag_n_o && !field_decrease_flag_n_o))
      else $error("open-drain output drove high");

   tick_period_a : assert property (
      tick_q |=> !tick_q [*2])
      else $error("sample tick too frequent");
   hold_between_a : assert property (
      (mode_q == ST_RUN && !first_q && !tick_q) |=> $stable(incr_out))
      else $error("incremental outputs changed between samples");
   quad_match_a : assert property (
      (mode_q == ST_RUN && !first_q)
      |-> (incr_out.a == pos_q[1] && incr_out.b == (pos_q[1] ^ pos_q[0])))
      else $error("A and B do not match the latched position");
   no_index_a : assert property (
      (mode_q == ST_RUN && first_q) |=> !incr_out.index)
      else $error("index pulse on leaving start-up");

   run_cv : cover property (@(posedge clk) disable iff (!resetn)
      mode_q == ST_WAIT_CS ##[1:20] mode_q == ST_RUN);
   strap_cv : cover property (@(posedge clk) disable iff (!resetn)
      mode_q == ST_SETTLE ##1 mode_q == ST_RUN);
   range_cv : cover property (@(posedge clk) disable iff (!resetn)
      fs_s.too_weak);
   index_cv : cover property (@(posedge clk) disable iff (!resetn)
      incr_out.index);
   recede_cv : cover property (
      field_decrease_flag_n_oe && !field_increase_flag_n_oe);
endmodule

// ### core/diag_pkg.sv
// Purpose: shared constants and types for the encoder fault diagnostics
// Assumes: 125 MHz system clock
// Notes:   times are kept in their own unit, cycle counts derived here
package diag_pkg;
   localparam int unsigned CLK_HZ          = 125_000_000;
   localparam int unsigned SAMPLE_RATE_HZ  = 10_000;
   localparam int unsigned SAMPLE_CYCLES   = CLK_HZ / SAMPLE_RATE_HZ;
   // power-up settling time in microseconds; a plain default, adjust per part
   localparam int unsigned POWERUP_SETTLE_US = 20_000;
   localparam int unsigned POWERUP_SETTLE_CYCLES =
      POWERUP_SETTLE_US * (CLK_HZ / 1_000_000);
   localparam int unsigned POS_W = 8;

   // field strength status from the analog front end
   typedef struct packed {
      logic too_strong;
      logic too_weak;
      logic rising;
      logic falling;
   } field_stat_t;

   // incremental output triple
   typedef struct packed {
      logic a;
      logic b;
      logic index;
   } incr_t;

   localparam incr_t INCR_ALL_HIGH = 3'h7;
   localparam incr_t INCR_IDLE     = 3'h0;
endpackage

// ### core/sync2.sv
// Purpose: two-flip-flop synchroniser for pin inputs
// Assumes: single clock, asynchronous active-low reset
// Notes:   first stage feeds only the second stage
module sync2 #(
   parameter int          W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         resetn,
   // data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// ### test/rx_controller_model.sv
// Purpose: receiving controller side of the encoder diagnostic pins
// Assumes: pull-ups on both flag lines and on A, B, index at the receiver
// Notes:   a released flag line reads the pull-up level, never the old value
module rx_controller_model
   import diag_pkg::*;
(
   // open-drain flag drivers
   input  wire logic  inc_o,
   input  wire logic  inc_oe,
   input  wire logic  dec_o,
   input  wire logic  dec_oe,
   // incremental lines
   input  wire incr_t incr,
   // resolved view
   output logic       inc_pin_n,
   output logic       dec_pin_n,
   output logic       fail_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   assign inc_pin_n = inc_oe ? inc_o : 1'b1;
   assign dec_pin_n = dec_oe ? dec_o : 1'b1;
   // all three high never occurs in normal running
   assign fail_seen = incr.a & incr.b & incr.index;
endmodule

// ### test/test_encoder_fault_diagnostics.sv
// Purpose: self-checking bench for the encoder fault diagnostics
// Assumes: short settle and sample counts so the run stays brief
// Notes:   flags are judged on the resolved pin levels from the model
module test_encoder_fault_diagnostics
   import diag_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SET = 50;
   localparam int SMP = 20;
   logic             clk, resetn, cs_n, done;
   logic             inc_o, inc_oe, dec_o, dec_oe;
   logic             inc_pin_n, dec_pin_n, fail_seen;
   field_stat_t      fs;
   logic [POS_W-1:0] pos;
   incr_t            incr;
   int               fails, n_compared, cycles;

   encoder_fault_diagnostics #(.SAMPLE_CNT(SMP), .SETTLE_CNT(SET))
   u_encoder_fault_diagnostics (.clk(clk), .resetn(resetn),
      .chip_select_n(cs_n), .field_stat(fs), .position(pos),
      .field_increase_flag_n_o(inc_o), .field_increase_flag_n_oe(inc_oe),
      .field_decrease_flag_n_o(dec_o), .field_decrease_flag_n_oe(dec_oe),
      .incr_out(incr), .startup_done(done));

   rx_controller_model u_rx_controller_model (.inc_o(inc_o),
      .inc_oe(inc_oe), .dec_o(dec_o), .dec_oe(dec_oe), .incr(incr),
      .inc_pin_n(inc_pin_n), .dec_pin_n(dec_pin_n), .fail_seen(fail_seen));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(string what, logic [2:0] seen, logic [2:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // a hang counts as a mismatch and still ends in the report
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         fails++;
         stop_test;
      end
   end

   // once running, the all-high marker must never appear
   always @(negedge clk)
      if (done === 1'b1) chk("run marker", {2'b0, fail_seen}, 3'h0);

   task automatic wait_done(int lim);
      for (int i = 0; i < lim && done !== 1'b1; i++) @(posedge clk);
      @(posedge clk);
   endtask

   task automatic do_reset(logic sel_n);
      resetn <= 1'b0;
      cs_n   <= sel_n;
      repeat (8) @(posedge clk);
      chk("reset pins", {inc_pin_n, dec_pin_n, fail_seen}, 3'h1);
      resetn <= 1'b1;
   endtask

   task automatic s_power_up;
      do_reset(1'b1);
      repeat (SET + 10) @(posedge clk);
      chk("held high", incr, INCR_ALL_HIGH);
      chk("held state", {done, fail_seen, 1'b0}, 3'h2);
      cs_n <= 1'b0;
      wait_done(20);
      chk("run entry", incr, 3'h6);
   endtask

   task automatic s_flags;
      field_stat_t fv [5] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1};
      logic [2:0]  ev [5] = '{3'h3, 3'h0, 3'h0, 3'h1, 3'h2};
      for (int i = 0; i < 5; i++) begin
         fs <= fv[i];
         repeat (5) @(posedge clk);
         chk("flags", {1'b0, inc_pin_n, dec_pin_n}, ev[i]);
      end
      fs <= 4'h0;
   endtask

   task automatic s_tick;
      cs_n <= 1'b1;
      pos  <= 8'h03;
      repeat (SMP + 5) @(posedge clk);
      chk("quad step", incr, 3'h4);
      pos  <= 8'h00;
      // next refresh lands on the checking edge, old phase is still read there
      repeat (5) @(posedge clk);
      chk("held between", incr, 3'h4);
      repeat (SMP) @(posedge clk);
      chk("index at zero", incr, 3'h1);
      chk("run kept", {2'b0, done}, 3'h1);
   endtask

   task automatic s_select_tied_low;
      pos <= 8'h00;
      do_reset(1'b0);
      repeat (SET / 2) @(posedge clk);
      chk("settling", incr, INCR_ALL_HIGH);
      chk("not running", {2'b0, done}, 3'h0);
      wait_done(SET + 20);
      chk("settle end", {2'b0, done}, 3'h1);
      // at position zero the first update keeps index low
      chk("run entry", incr, 3'h0);
      repeat (SMP) @(posedge clk);
      chk("index later", incr, 3'h1);
   endtask

   initial begin
      resetn <= 1'b0;
      cs_n   <= 1'b1;
      fs     <= 4'h0;
      pos    <= 8'h02;
      fails = 0;
      n_compared = 0;
      cycles = 0;
      s_power_up;
      s_flags;
      s_tick;
      s_select_tied_low;
      stop_test;
   end
endmodule
